/* lbs_regs.svh */
// Register map, reset values and timing counts of the ballast sequencer
// Behaviour
// [R1] Preheat starts at top frequency, holds until PFC, timer node, lamp voltage good.
// [R2] Preheat: low-side current above threshold raises frequency, below lowers it.
// [R3] Fixed preheat: resistor current vs four fifths oscillator current steers frequency.
// [R4] Current and fixed-frequency preheat adjustments act together, not exclusively.
// [R5] Programmable timer ends preheat; sequencer then goes straight to ignition.
// [R6] Ignition sweeps frequency down until lamp-on or lowest frequency.
// [R7] Lamp-on after fixed delay: current above, voltage below for over half each cycle.
// [R8] Saturation, overvoltage or hard switching in ignition freezes frequency, starts fault timer.
// [R9] Fault timeout: first attempt goes to auto-restart, otherwise to stop.
// [R10] Auto-restart draws restart current; supply below restart level returns to standby.
// [R11] Burn enables lamp current loop, protections and boost.
// [R12] Setpoint is reference when dimming absent or above it, else dimming level.
// [R13] Dimming level clamped to reference; open input floats up to that clamp.
// [R14] Burn loop follows lamp current minus setpoint; higher integrator means lower frequency.
// [R15] Frequency never below lowest limit except during boost; stays there if unregulated. After boost, current above setpoint raises it from below.
// [R16] Grounded lamp current sense gives lowest frequency and no dimming.
// [R17] Supply stop or overtemperature halts oscillation with low-side gate high, then standby.
// [R18] Thresholds arrive as synchronous flags; frequency is bounded up/down control word.
`ifndef LBS_REGS_SVH
`define LBS_REGS_SVH

`define LBS_OFF_CTRL 8'h00
`define LBS_OFF_STATUS 8'h04
`define LBS_OFF_FREQ 8'h08
`define LBS_OFF_PH_TIME 8'h0C
`define LBS_OFF_FAULT_TIME 8'h10
`define LBS_OFF_REF_LEVEL 8'h14
`define LBS_OFF_IRQ_STAT 8'h18
`define LBS_OFF_IRQ_MASK 8'h1C

`define LBS_CTRL_RUN 0
`define LBS_CTRL_FIXED 1
`define LBS_STAT_ATTEMPT 4
`define LBS_STAT_LAMP_ON 5

`define LBS_IRQ_LAMP_ON 0
`define LBS_IRQ_FAULT 1
`define LBS_IRQ_HALT 2
`define LBS_IRQ_STOP 3

`define LBS_CTRL_RST 2'h1
`define LBS_PH_TIME_RST 16'h2000
`define LBS_FAULT_TIME_RST 16'h1000
`define LBS_REF_LEVEL_RST 8'hC0
`define LBS_IRQ_MASK_RST 4'h0

`define LBS_FREQ_MAX 10'h3FF
`define LBS_FREQ_MIN 10'h080
`define LBS_FREQ_BOOST_MIN 10'h040

`define LBS_CLK_PERIOD_NS 20
`define LBS_LOD_DELAY_NS 20000
`define LBS_LOD_CYCLES ((`LBS_LOD_DELAY_NS + `LBS_CLK_PERIOD_NS - 1) / `LBS_CLK_PERIOD_NS)

`define LBS_RESP_OKAY 2'h0
`define LBS_RESP_SLVERR 2'h2

`endif

/* lbs_pkg.sv */
// Types of the ballast sequencer
package lbs_pkg;

	typedef enum logic [2:0] {
		lbs_standby,
		lbs_preheat,
		lbs_ignite,
		lbs_restart,
		lbs_burn,
		lbs_stop
	} lbs_mode_t;

	typedef struct packed {
		lbs_mode_t fsm;
		logic [9:0] freq;
		logic [15:0] tmr;
		logic fault_run;
		logic attempt2;
		logic halt_pend;
		logic [1:0] ctrl;
		logic [15:0] ph_time;
		logic [15:0] fault_time;
		logic [7:0] ref_level;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic osc_run;
		logic gate_hold;
		logic restart_en;
		logic burn_en;
		logic irq;
	} lbs_state_t;

	typedef struct packed {
		logic [7:0] below_cnt;
		logic [7:0] total_cnt;
		logic cycle_good;
		logic [15:0] delay_cnt;
		logic lamp_on;
	} lbs_lod_t;

endpackage

/* lbs_lamp_detect.sv */
// Lamp-on detector: half-cycle voltage test, current test and delay
`timescale 1ns/10ps
`default_nettype none
`include "lbs_regs.svh"

module lbs_lamp_detect
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic enable, // Detection armed
	input wire logic osc_cycle, // Pulse at start of each switching cycle
	input wire logic vfb_below_lod, // Lamp voltage below detection level
	input wire logic ifb_above_lod, // Rectified lamp current above level
	output logic lamp_on // Lamp-on declared
);

	localparam logic [15:0] LOD_CYC = 16'(`LBS_LOD_CYCLES);

	lbs_pkg::lbs_lod_t st;
	lbs_pkg::lbs_lod_t nx;

	always_comb
	begin
		nx = st;
		nx.total_cnt = st.total_cnt + ((st.total_cnt != 8'hFF) ? 8'h01 : 8'h00);
		nx.below_cnt = st.below_cnt + ((vfb_below_lod && st.below_cnt != 8'hFF) ? 8'h01 : 8'h00);
		if (osc_cycle)
		begin
			// Strictly more than half of the finished cycle
			nx.cycle_good = ({1'b0, st.below_cnt} << 1) > {1'b0, st.total_cnt}; // [R7]
			nx.total_cnt = 8'h00;
			nx.below_cnt = 8'h00;
		end
		if (!enable || !ifb_above_lod || !st.cycle_good)
		begin
			nx.delay_cnt = 16'h0000; // [R7]
			nx.lamp_on = 1'b0;
		end
		else if (st.delay_cnt >= LOD_CYC)
		begin
			nx.lamp_on = 1'b1; // [R7]
		end
		else
		begin
			nx.delay_cnt = st.delay_cnt + 16'h0001;
		end
		if (!enable)
		begin
			nx.cycle_good = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= nx;
		end
	end

	assign lamp_on = st.lamp_on;

endmodule
`default_nettype wire

/* lbs_ctrl.sv */
// Ballast state sequencer with frequency command and AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
`include "lbs_regs.svh"

module lbs_ctrl
(
	input wire logic aclk, // System clock, 50 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic vdd_startup_ok, // Supply above start-up level
	input wire logic vdd_stop, // Supply below stop level
	input wire logic vdd_restart_low, // Supply below restart level
	input wire logic vdd_reset_low, // Supply below reset level
	input wire logic overtemp, // Overtemperature flag
	input wire logic pfc_feedback_ok, // PFC output sufficient
	input wire logic preheat_timer_cap_ok, // Timer node above short level
	input wire logic lamp_voltage_sense_ok, // Lamp voltage above short level
	input wire logic low_side_current_sense_high, // Above preheat control level
	input wire logic preheat_set_res_larger, // Resistor current above 4/5 VCO
	input wire logic osc_cycle, // Pulse per switching cycle
	input wire logic vfb_below_lod, // Lamp voltage below lamp-on level
	input wire logic ifb_above_lod, // Lamp current above lamp-on level
	input wire logic fault_saturation, // Coil saturation regulation active
	input wire logic fault_overvoltage, // Lamp overvoltage regulation active
	input wire logic fault_hard_switch, // Hard switching regulation active
	input wire logic [7:0] lamp_current_level, // Rectified lamp current level
	input wire logic [7:0] brightness_setpoint_input, // Dimming level
	input wire logic brightness_present, // Dimming input connected
	input wire logic boost_active, // Boost lowers frequency floor
	input wire logic low_side_gate, // Low-side gate is high
	output logic [9:0] freq_cmd, // Switching frequency control word
	output logic osc_run, // Half-bridge oscillating
	output logic standby_gate_on, // Hold low-side gate high
	output logic restart_current_en, // Draw restart supply current
	output logic lamp_reg_en, // Lamp current loop enabled
	output logic prot_en, // Protections enabled
	output logic boost_en, // Boost function enabled
	output logic irq // Interrupt, active high level
);

	localparam logic [9:0] F_MAX = `LBS_FREQ_MAX;
	localparam logic [9:0] F_MIN = `LBS_FREQ_MIN;
	localparam logic [9:0] F_BMIN = `LBS_FREQ_BOOST_MIN;

	lbs_pkg::lbs_state_t st;
	lbs_pkg::lbs_state_t nx;
	logic lamp_on;

	function automatic logic [9:0] f_up(input logic [9:0] f);
		f_up = (f < F_MAX) ? f + 10'h001 : F_MAX; // [R18]
	endfunction

	function automatic logic [9:0] f_down(input logic [9:0] f, input logic [9:0] floor_f);
		f_down = (f > floor_f) ? f - 10'h001 : floor_f; // [R18]
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	lbs_lamp_detect u_lod
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(st.fsm == lbs_pkg::lbs_ignite),
		.osc_cycle(osc_cycle),
		.vfb_below_lod(vfb_below_lod),
		.ifb_above_lod(ifb_above_lod),
		.lamp_on(lamp_on)
	);

	logic [7:0] dim_clamped;
	logic [7:0] setpoint;
	logic ph_ready;
	logic ign_fault;
	logic [3:0] ev;
	logic [3:0] w1c;
	logic wr_go;
	logic [31:0] wv;
	logic [31:0] rv;
	logic rd_ok;

	always_comb
	begin
		nx = st;
		ev = 4'h0;
		w1c = 4'h0;
		wv = 32'h0000_0000;
		rv = 32'h0000_0000;
		rd_ok = 1'b1;
		// Dimming clamp and setpoint select
		dim_clamped = (brightness_setpoint_input > st.ref_level) ? st.ref_level
			: brightness_setpoint_input; // [R13]
		setpoint = brightness_present ? dim_clamped : st.ref_level; // [R12]
		ph_ready = pfc_feedback_ok && preheat_timer_cap_ok && lamp_voltage_sense_ok;
		ign_fault = fault_saturation || fault_overvoltage || fault_hard_switch;

		case (st.fsm)
			lbs_pkg::lbs_standby:
			begin
				if (vdd_startup_ok && st.ctrl[`LBS_CTRL_RUN])
				begin
					nx.fsm = lbs_pkg::lbs_preheat;
					nx.freq = F_MAX; // [R1]
					nx.tmr = 16'h0000;
				end
			end
			lbs_pkg::lbs_preheat:
			begin
				if (!ph_ready)
				begin
					nx.freq = F_MAX; // [R1]
				end
				else
				begin
					// Both preheat loops act at once; either may push upward
					if (low_side_current_sense_high
						|| (st.ctrl[`LBS_CTRL_FIXED] && preheat_set_res_larger)) // [R4]
					begin
						nx.freq = f_up(st.freq); // [R2] [R3]
					end
					else
					begin
						nx.freq = f_down(st.freq, F_MIN); // [R2] [R3]
					end
					if (st.tmr >= st.ph_time)
					begin
						nx.fsm = lbs_pkg::lbs_ignite; // [R5]
						nx.tmr = 16'h0000;
						nx.fault_run = 1'b0;
					end
					else
					begin
						nx.tmr = st.tmr + 16'h0001; // [R5]
					end
				end
			end
			lbs_pkg::lbs_ignite:
			begin
				if (lamp_on)
				begin
					nx.fsm = lbs_pkg::lbs_burn; // [R6]
					nx.fault_run = 1'b0;
					ev[`LBS_IRQ_LAMP_ON] = 1'b1;
				end
				else if (st.fault_run)
				begin
					// Frequency frozen where the fault appeared
					if (st.tmr >= st.fault_time)
					begin
						ev[`LBS_IRQ_FAULT] = 1'b1;
						nx.fault_run = 1'b0;
						if (st.attempt2)
						begin
							nx.fsm = lbs_pkg::lbs_stop; // [R9]
							ev[`LBS_IRQ_STOP] = 1'b1;
						end
						else
						begin
							nx.fsm = lbs_pkg::lbs_restart; // [R9]
							nx.attempt2 = 1'b1;
						end
					end
					else
					begin
						nx.tmr = st.tmr + 16'h0001; // [R8]
					end
				end
				else if (ign_fault || st.freq <= F_MIN)
				begin
					nx.fault_run = 1'b1; // [R8] [R6]
					nx.tmr = 16'h0000;
				end
				else
				begin
					nx.freq = f_down(st.freq, F_MIN); // [R6]
				end
			end
			lbs_pkg::lbs_restart:
			begin
				if (vdd_restart_low)
				begin
					nx.fsm = lbs_pkg::lbs_standby; // [R10]
				end
			end
			lbs_pkg::lbs_burn:
			begin
				// Current above setpoint drives the integrator down, frequency up
				if (lamp_current_level > setpoint)
				begin
					nx.freq = f_up(st.freq); // [R14]
				end
				else if (lamp_current_level < setpoint)
				begin
					nx.freq = f_down(st.freq, boost_active ? F_BMIN : F_MIN); // [R15] [R16]
				end
				else if (!boost_active && st.freq < F_MIN)
				begin
					nx.freq = F_MIN; // [R15]
				end
			end
			lbs_pkg::lbs_stop:
			begin
				nx.freq = F_MAX;
			end
			default:
			begin
				nx.fsm = lbs_pkg::lbs_standby;
			end
		endcase

		// Stop or overtemperature halts only while the low-side gate is high
		if (st.osc_run && (vdd_stop || overtemp))
		begin
			nx.halt_pend = 1'b1; // [R17]
		end
		if (st.osc_run && (st.halt_pend || vdd_stop || overtemp) && low_side_gate)
		begin
			nx.fsm = lbs_pkg::lbs_standby; // [R17]
			nx.halt_pend = 1'b0;
			nx.fault_run = 1'b0;
			ev[`LBS_IRQ_HALT] = 1'b1;
		end
		if (vdd_reset_low)
		begin
			nx.fsm = lbs_pkg::lbs_standby;
			nx.attempt2 = 1'b0;
			nx.halt_pend = 1'b0;
			nx.fault_run = 1'b0;
		end
		if (nx.fsm != lbs_pkg::lbs_preheat && nx.fsm != lbs_pkg::lbs_ignite
			&& nx.fsm != lbs_pkg::lbs_burn)
		begin
			nx.halt_pend = 1'b0;
		end

		// Write channel: both address and data taken in one handshake
		wr_go = s_axi_awvalid && s_axi_wvalid && !st.awready && !st.bvalid;
		nx.awready = wr_go;
		nx.wready = wr_go;
		if (st.bvalid && s_axi_bready)
		begin
			nx.bvalid = 1'b0;
		end
		if (st.awready)
		begin
			nx.bvalid = 1'b1;
			nx.bresp = `LBS_RESP_OKAY;
			case (s_axi_awaddr)
				`LBS_OFF_CTRL:
				begin
					wv = merge({30'h0, st.ctrl}, s_axi_wdata, s_axi_wstrb);
					nx.ctrl = wv[1:0];
				end
				`LBS_OFF_PH_TIME:
				begin
					wv = merge({16'h0, st.ph_time}, s_axi_wdata, s_axi_wstrb);
					nx.ph_time = wv[15:0];
				end
				`LBS_OFF_FAULT_TIME:
				begin
					wv = merge({16'h0, st.fault_time}, s_axi_wdata, s_axi_wstrb);
					nx.fault_time = wv[15:0];
				end
				`LBS_OFF_REF_LEVEL:
				begin
					wv = merge({24'h0, st.ref_level}, s_axi_wdata, s_axi_wstrb);
					nx.ref_level = wv[7:0];
				end
				`LBS_OFF_IRQ_STAT:
				begin
					w1c = s_axi_wstrb[0] ? s_axi_wdata[3:0] : 4'h0;
				end
				`LBS_OFF_IRQ_MASK:
				begin
					wv = merge({28'h0, st.irq_mask}, s_axi_wdata, s_axi_wstrb);
					nx.irq_mask = wv[3:0];
				end
				`LBS_OFF_STATUS, `LBS_OFF_FREQ:
				begin
					nx.bresp = `LBS_RESP_OKAY;
				end
				default:
				begin
					nx.bresp = `LBS_RESP_SLVERR;
				end
			endcase
		end
		// Set wins over a simultaneous write-one-to-clear
		nx.irq_stat = (st.irq_stat & ~w1c) | ev;

		// Read channel
		nx.arready = s_axi_arvalid && !st.arready && !st.rvalid;
		if (st.rvalid && s_axi_rready)
		begin
			nx.rvalid = 1'b0;
		end
		if (st.arready)
		begin
			case (s_axi_araddr)
				`LBS_OFF_CTRL: rv = {30'h0, st.ctrl};
				`LBS_OFF_STATUS: rv = {26'h0, lamp_on, st.attempt2, 1'b0, st.fsm};
				`LBS_OFF_FREQ: rv = {22'h0, st.freq};
				`LBS_OFF_PH_TIME: rv = {16'h0, st.ph_time};
				`LBS_OFF_FAULT_TIME: rv = {16'h0, st.fault_time};
				`LBS_OFF_REF_LEVEL: rv = {24'h0, st.ref_level};
				`LBS_OFF_IRQ_STAT: rv = {28'h0, st.irq_stat};
				`LBS_OFF_IRQ_MASK: rv = {28'h0, st.irq_mask};
				default: rd_ok = 1'b0;
			endcase
			nx.rvalid = 1'b1;
			nx.rdata = rv;
			nx.rresp = rd_ok ? `LBS_RESP_OKAY : `LBS_RESP_SLVERR;
		end

		// Registered port images
		nx.osc_run = (nx.fsm == lbs_pkg::lbs_preheat) || (nx.fsm == lbs_pkg::lbs_ignite)
			|| (nx.fsm == lbs_pkg::lbs_burn);
		nx.gate_hold = (nx.fsm == lbs_pkg::lbs_standby);
		nx.restart_en = (nx.fsm == lbs_pkg::lbs_restart); // [R10]
		nx.burn_en = (nx.fsm == lbs_pkg::lbs_burn); // [R11]
		nx.irq = |(nx.irq_stat & nx.irq_mask);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.fsm <= lbs_pkg::lbs_standby;
			st.freq <= F_MAX;
			st.ctrl <= `LBS_CTRL_RST;
			st.ph_time <= `LBS_PH_TIME_RST;
			st.fault_time <= `LBS_FAULT_TIME_RST;
			st.ref_level <= `LBS_REF_LEVEL_RST;
			st.irq_mask <= `LBS_IRQ_MASK_RST;
			st.gate_hold <= 1'b1;
		end
		else
		begin
			st <= nx;
		end
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign freq_cmd = st.freq;
	assign osc_run = st.osc_run;
	assign standby_gate_on = st.gate_hold;
	assign restart_current_en = st.restart_en;
	assign lamp_reg_en = st.burn_en;
	assign prot_en = st.burn_en;
	assign boost_en = st.burn_en;
	assign irq = st.irq;

endmodule
`default_nettype wire

/* lbs_ctrl_assertions.sv */
// Port checker of the ballast sequencer, bound into lbs_ctrl
`timescale 1ns/10ps
`default_nettype none
module lbs_ctrl_checker
(
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic [9:0] freq_cmd, // Frequency word
	input wire logic osc_run, // Oscillating
	input wire logic standby_gate_on, // Standby gate hold
	input wire logic restart_current_en, // Restart current
	input wire logic lamp_reg_en, // Lamp loop on
	input wire logic prot_en, // Protections on
	input wire logic boost_en, // Boost on
	input wire logic boost_active, // Boost request
	input wire logic low_side_gate, // Gate level
	input wire logic vdd_reset_low, // Supply reset level
	input wire logic [7:0] lamp_current_level, // Lamp current
	input wire logic brightness_present // Dimming connected
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_preheat_top: assert property ($rose(osc_run) |-> freq_cmd == 10'h3FF)
		else $error("preheat entered below top frequency");
	a_floor_osc: assert property (osc_run && !lamp_reg_en |-> freq_cmd >= 10'h080)
		else $error("frequency below floor outside burn");
	a_floor_any: assert property (freq_cmd >= 10'h040)
		else $error("frequency below boost floor");
	a_burn_enables: assert property (lamp_reg_en |-> prot_en && boost_en && osc_run)
		else $error("burn without loop, protections or boost");
	a_restart_alone: assert property (restart_current_en |-> !osc_run && !standby_gate_on)
		else $error("restart current outside restart");
	a_standby_still: assert property (standby_gate_on |-> !osc_run)
		else $error("oscillating in standby");
	a_burn_raise: assert property (lamp_reg_en && lamp_current_level == 8'hFF &&
		freq_cmd != 10'h3FF ##1 lamp_reg_en |-> freq_cmd == $past(freq_cmd) + 10'h001)
		else $error("high lamp current did not raise frequency");
	a_burn_ground: assert property (lamp_reg_en && lamp_current_level == 8'h00 &&
		!brightness_present && !boost_active && freq_cmd > 10'h080 ##1 lamp_reg_en
		|-> freq_cmd == $past(freq_cmd) - 10'h001)
		else $error("grounded lamp current did not lower frequency");
	a_floor_hold: assert property (lamp_reg_en && !boost_active &&
		lamp_current_level == 8'h00 && freq_cmd == 10'h080 ##1 lamp_reg_en
		|-> freq_cmd == 10'h080)
		else $error("frequency left the floor");
	a_halt_gate: assert property ($rose(standby_gate_on) && $past(osc_run) &&
		!$past(vdd_reset_low) |-> $past(low_side_gate))
		else $error("halt with low-side gate low");
endmodule

bind lbs_ctrl lbs_ctrl_checker u_chk (.aclk, .aresetn, .freq_cmd, .osc_run, .standby_gate_on,
	.restart_current_en, .lamp_reg_en, .prot_en, .boost_en, .boost_active, .low_side_gate,
	.vdd_reset_low, .lamp_current_level, .brightness_present);
`default_nettype wire

/* lbs_tank_model.sv */
// Half-bridge, lamp tank and sensor model
`timescale 1ns/10ps
`default_nettype none
module lbs_tank_model
(
	input wire logic aclk, // Clock
	input wire logic osc_run, // Half-bridge running
	input wire logic standby_gate_on, // Gate held in standby
	input wire logic [9:0] freq_cmd, // Frequency word
	input wire logic lamp_ok, // Lamp able to strike
	output logic osc_cycle, // Cycle start pulse
	output logic low_side_gate, // Low-side gate level
	output logic vfb_below_lod, // Voltage below lamp-on level
	output logic ifb_above_lod // Current above lamp-on level
);
	logic [2:0] ph;
	logic lit;
	// Eight-clock switching cycle, held at phase zero while stopped
	always_ff @(posedge aclk)
	begin
		ph <= osc_run ? ph + 3'h1 : 3'h0;
		lit <= osc_run && lamp_ok && (lit || freq_cmd < 10'h3C0);
	end
	assign osc_cycle = osc_run && ph == 3'h0;
	assign low_side_gate = osc_run ? !ph[2] : standby_gate_on;
	// Struck lamp: voltage low six clocks of eight
	assign vfb_below_lod = lit && ph > 3'h1;
	assign ifb_above_lod = lit;
endmodule
`default_nettype wire

/* lamp_ballast_state_control_test.sv */
// Self-checking bench of the ballast sequencer
`timescale 1ns/10ps
`default_nettype none
`include "lbs_regs.svh"
module lamp_ballast_state_control_test;
	logic aclk, aresetn, vdd_startup_ok, vdd_stop, vdd_restart_low, vdd_reset_low, overtemp;
	logic pfc_feedback_ok, preheat_timer_cap_ok, lamp_voltage_sense_ok, preheat_set_res_larger;
	logic low_side_current_sense_high, fault_saturation, fault_overvoltage, fault_hard_switch;
	logic brightness_present, boost_active, lamp_ok, osc_cycle, low_side_gate;
	logic vfb_below_lod, ifb_above_lod, osc_run, standby_gate_on, restart_current_en;
	logic lamp_reg_en, prot_en, boost_en, irq;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, wrsp;
	logic [3:0] s_axi_wstrb;
	logic [7:0] s_axi_awaddr, s_axi_araddr, lamp_current_level, brightness_setpoint_input;
	logic [9:0] freq_cmd, f0;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;

	lbs_ctrl DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .vdd_startup_ok, .vdd_stop, .vdd_restart_low, .vdd_reset_low, .overtemp,
		.pfc_feedback_ok, .preheat_timer_cap_ok, .lamp_voltage_sense_ok,
		.low_side_current_sense_high, .preheat_set_res_larger, .osc_cycle, .vfb_below_lod,
		.ifb_above_lod, .fault_saturation, .fault_overvoltage, .fault_hard_switch,
		.lamp_current_level, .brightness_setpoint_input, .brightness_present, .boost_active,
		.low_side_gate, .freq_cmd, .osc_run, .standby_gate_on, .restart_current_en, .lamp_reg_en,
		.prot_en, .boost_en, .irq);
	lbs_tank_model u_tank (.aclk, .osc_run, .standby_gate_on, .freq_cmd, .lamp_ok, .osc_cycle,
		.low_side_gate, .vfb_below_lod, .ifb_above_lod);

	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test;
		$display("miscompares %0d of %0d compares", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && s_axi_awready !== 1'b1)
			|| (s_axi_wvalid && s_axi_wready !== 1'b1));
		while (s_axi_bvalid !== 1'b1)
			@(posedge aclk);
		wrsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (s_axi_arready !== 1'b1)
			@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1)
			@(posedge aclk);
		rdat = s_axi_rdata;
		rrsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Frequency change over four clocks
	task automatic slope(input string nm, input logic [9:0] d);
		logic [9:0] x;
		repeat (2) @(posedge aclk);
		f0 = freq_cmd;
		repeat (4) @(posedge aclk);
		x = f0 + d;
		chk(nm, x, freq_cmd);
	endtask

	task automatic t_regs;
		rd(`LBS_OFF_CTRL);
		chk("ctrl", 32'h1, rdat);
		rd(`LBS_OFF_PH_TIME);
		chk("ph_time", 32'h2000, rdat);
		rd(`LBS_OFF_FAULT_TIME);
		chk("fault_time", 32'h1000, rdat);
		rd(`LBS_OFF_REF_LEVEL);
		chk("ref_level", 32'hC0, rdat);
		rd(`LBS_OFF_IRQ_MASK);
		chk("irq_mask", 32'h0, rdat);
		rd(8'h20);
		chk("unmapped resp", 32'h2, rrsp);
		chk("unmapped data", 32'h0, rdat);
		wr(`LBS_OFF_CTRL, 32'h3);
		chk("ctrl wresp", 32'h0, wrsp);
		wr(`LBS_OFF_PH_TIME, 32'h30);
		wr(`LBS_OFF_FAULT_TIME, 32'h4);
		wr(8'h24, 32'h0);
		chk("unmapped wresp", 32'h2, wrsp);
		rd(`LBS_OFF_PH_TIME);
		chk("ph_time write", 32'h30, rdat);
	endtask

	task automatic t_preheat;
		vdd_startup_ok <= 1'b1;
		{preheat_timer_cap_ok, lamp_voltage_sense_ok} <= 2'b11;
		repeat (8) @(posedge aclk);
		chk("preheat hold", 32'h3FF, freq_cmd);
		pfc_feedback_ok <= 1'b1;
		repeat (16) @(posedge aclk);
		slope("preheat down", 10'h3FC);
		low_side_current_sense_high <= 1'b1;
		slope("preheat up", 10'h004);
		low_side_current_sense_high <= 1'b0;
		preheat_set_res_larger <= 1'b1;
		slope("fixed up", 10'h004);
		low_side_current_sense_high <= 1'b1;
		slope("both up", 10'h004);
		{low_side_current_sense_high, preheat_set_res_larger} <= 2'b00;
	endtask

	task automatic t_fail1;
		repeat (40) @(posedge aclk);
		slope("ignite sweep", 10'h3FC);
		while (restart_current_en !== 1'b1)
			@(posedge aclk);
		rd(`LBS_OFF_STATUS);
		chk("state restart", 32'h3, rdat[2:0]);
		rd(`LBS_OFF_IRQ_STAT);
		chk("fault event", 32'h2, rdat);
		chk("masked irq", 32'h0, irq);
		wr(`LBS_OFF_IRQ_MASK, 32'hF);
		chk("irq raised", 32'h1, irq);
		wr(`LBS_OFF_IRQ_STAT, 32'hF);
		@(posedge aclk);
		chk("irq cleared", 32'h0, irq);
		vdd_restart_low <= 1'b1;
		while (standby_gate_on !== 1'b1)
			@(posedge aclk);
		chk("restart left", 32'h0, restart_current_en);
		vdd_restart_low <= 1'b0;
	endtask

	task automatic t_fail2;
		while (osc_run !== 1'b1 || freq_cmd > 10'h300)
			@(posedge aclk);
		fault_saturation <= 1'b1;
		repeat (2) @(posedge aclk);
		f0 = freq_cmd;
		repeat (2) @(posedge aclk);
		chk("fault hold", f0, freq_cmd);
		while (osc_run !== 1'b0)
			@(posedge aclk);
		rd(`LBS_OFF_STATUS);
		chk("state stop", 32'h15, rdat[5:0]);
		fault_saturation <= 1'b0;
		repeat (20) @(posedge aclk);
		chk("stop holds", 32'h0, osc_run);
	endtask

	task automatic t_burn;
		lamp_ok <= 1'b1;
		wr(`LBS_OFF_FAULT_TIME, 32'h800);
		vdd_reset_low <= 1'b1;
		@(posedge aclk);
		vdd_reset_low <= 1'b0;
		while (ifb_above_lod !== 1'b1)
			@(posedge aclk);
		n = 0;
		while (lamp_reg_en !== 1'b1)
		begin
			@(posedge aclk);
			n++;
		end
		chk("lamp-on delay", 32'h1, n >= 1000 && n <= 1030);
		chk("burn enables", 32'h3, {prot_en, boost_en});
		rd(`LBS_OFF_STATUS);
		chk("state burn", 32'h4, rdat[2:0]);
		lamp_current_level <= 8'hFF;
		slope("burn up", 10'h004);
		{brightness_present, brightness_setpoint_input, lamp_current_level} <= {1'b1, 16'h4050};
		slope("dimmed up", 10'h004);
		brightness_present <= 1'b0;
		slope("undimmed down", 10'h3FC);
		{brightness_present, brightness_setpoint_input, lamp_current_level} <= {1'b1, 16'hF0D0};
		slope("dim clamp up", 10'h004);
		{brightness_present, lamp_current_level} <= 9'h000;
		repeat (100) @(posedge aclk);
		chk("floor", 32'h80, freq_cmd);
		boost_active <= 1'b1;
		slope("boost down", 10'h3FC);
		repeat (100) @(posedge aclk);
		chk("boost floor", 32'h40, freq_cmd);
	endtask

	task automatic t_halt;
		{boost_active, vdd_startup_ok, overtemp} <= 3'b001;
		repeat (20) @(posedge aclk);
		chk("halt standby", 32'h1, standby_gate_on);
		rd(`LBS_OFF_IRQ_STAT);
		chk("halt event", 32'h1, rdat[2]);
		chk("halt irq", 32'h1, irq);
	endtask

	initial
	begin
		{vdd_startup_ok, vdd_stop, vdd_restart_low, vdd_reset_low, overtemp, pfc_feedback_ok,
			preheat_timer_cap_ok, lamp_voltage_sense_ok, preheat_set_res_larger, lamp_ok,
			low_side_current_sense_high, fault_saturation, fault_overvoltage, fault_hard_switch,
			brightness_present, boost_active, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
			s_axi_arvalid, s_axi_rready, aresetn} = '0;
		{s_axi_awaddr, s_axi_araddr, lamp_current_level, brightness_setpoint_input} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_preheat();
		t_fail1();
		t_fail2();
		t_burn();
		t_halt();
		stop_test();
	end
endmodule
`default_nettype wire
